// file: mdfr_defs.vh
// Constants for the motor driver fault response block
`ifndef MDFR_DEFS_VH
`define MDFR_DEFS_VH

// Register byte offsets
`define MDFR_CFG_OFS       8'h00
`define MDFR_WDT_OFS       8'h04
`define MDFR_CTRL_OFS      8'h08
`define MDFR_STAT_OFS      8'h0C

// Configuration fields
`define MDFR_CFG_PTO_EN    0
`define MDFR_CFG_PRATE_EN  1
`define MDFR_CFG_UPLIM_LSB 2
`define MDFR_CFG_UP_MODE   5
`define MDFR_CFG_LOLIM_LSB 6
`define MDFR_CFG_LO_MODE   9
`define MDFR_CFG_WDT_EN    10
`define MDFR_CFG_WDT_ACT   11
`define MDFR_CFG_CAP_EN    12
`define MDFR_CFG_SAT_EN    13
`define MDFR_CFG_HWR_EN    14
`define MDFR_CFG_WIDTH     15
`define MDFR_CFG_RESET     15'h0000
`define MDFR_WDT_RESET     8'hFF

// Control fields
`define MDFR_CTRL_CLEAR    0
`define MDFR_CTRL_TICKLE   1

// Supply scale: codes in 0.5 V steps
`define MDFR_UP_BASE       8'h28
`define MDFR_UP_STEP       8'h04
`define MDFR_LO_BASE       8'h08
`define MDFR_LO_STEP       8'h02
`define MDFR_UP_HYS        8'h02
`define MDFR_LO_HYS        8'h01

// Timing
`define MDFR_CLK_KHZ       200000
`define MDFR_PROBE_TO_MS   500
`define MDFR_RETRY_MS      100
`define MDFR_WDT_TICK_MS   1

`endif

// file: mdfr_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module mdfr_sync (
    input  wire CLK,
    input  wire ARST_N,
    input  wire PIN,
    output reg  LEVEL
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            LEVEL <= 1'b0;
        end else begin
            s1 <= PIN;
            s2 <= s1;
            s3 <= s2;
            // Only a settled value passes
            if (s2 == s3) begin
                LEVEL <= s3;
            end
        end
    end
endmodule // mdfr_sync

// file: mdfr_fault_response.v
// Fault supervision and power stage response with AHB-Lite registers
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "mdfr_defs.vh"

// Notes on behaviour
// (RULE1) With probe timeout enabled, a probe ramp longer than its limit faults, goes hi-z and retries.
// (RULE2) With probe rate enabled, a pulse starting before the last decayed faults, goes hi-z, retries.
// (RULE3) A supply over the nonzero upper limit goes hi-z, latched or recovered below limit minus 1 V.
// (RULE4) A supply under the nonzero lower limit goes hi-z, latched or recovered above limit plus 0.5 V.
// (RULE5) A missed host tickle while checking faults, keeping the stage or latching hi-z by action mode.
// (RULE6) Supply current over the enabled cap reports and restricts speed until it drops below.
// (RULE7) Enabled loop saturation is reported with the stage active and clears when the loop settles.
// (RULE8) A reported heat warning sets the driver fault and clears below threshold minus hysteresis.
// (RULE9) Heat shutdown sets the driver fault, goes hi-z and recovers below threshold minus hysteresis.
// (RULE10) Motor supply lockout turns off stage, pump and logic and holds everything in reset.
// (RULE11) Analog rail lockout turns off stage, pump and controller and holds everything in reset.
// (RULE12) Step-down feedback lockout turns off both regulator switches and holds reset.
// (RULE13) Pump rail undervoltage turns off the stage, pulls the fault pin and sets driver and pump flags.
// (RULE14) The pump low flag stays set after recovery until the host clears it.
// (RULE15) A latched fault is released only by a clear command once its condition has gone.
// (RULE16) The fault pin is low while any reported fault is active or latched; the latched f_pump alone does not pull it low, and lockout holds it high.
// (RULE17) A retry fault starts the retry timer, and its expiry re-enables the stage and clears the flag.
module mdfr_fault_response #(
    parameter PROBE_TO_CYC = `MDFR_PROBE_TO_MS * `MDFR_CLK_KHZ,
    parameter RETRY_CYC    = `MDFR_RETRY_MS * `MDFR_CLK_KHZ,
    parameter WDT_TICK_CYC = `MDFR_WDT_TICK_MS * `MDFR_CLK_KHZ
) (
    input  wire        CLK,
    input  wire        ARST_N,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire        HREADYOUT,
    output wire        HRESP,
    output reg  [31:0] HRDATA,
    input  wire [7:0]  SUPPLY_LEVEL,
    input  wire        SUPPLY_CURRENT_OVER,
    input  wire        CURRENT_LOOP_SAT,
    input  wire        SPEED_LOOP_SAT,
    input  wire        REFERENCE_REACHED,
    input  wire        PROBE_RAMP_ACTIVE,
    input  wire        PROBE_PULSE_START,
    input  wire        PROBE_DECAYED,
    input  wire        MOTOR_SUPPLY_UV,
    input  wire        ANALOG_RAIL_UV,
    input  wire        STEP_DOWN_FEEDBACK_UV,
    input  wire        PUMP_RAIL_UV,
    input  wire        HEAT_WARNING_ABOVE,
    input  wire        HEAT_WARNING_HOLD,
    input  wire        HEAT_SHUTDOWN_ABOVE,
    input  wire        HEAT_SHUTDOWN_HOLD,
    output wire        FAULT_INDICATOR_PIN_N,
    output wire        STAGE_ENABLE,
    output wire        PUMP_ENABLE,
    output wire        STEP_DOWN_SWITCH_ENABLE,
    output wire        CONTROLLER_ACTIVE,
    output wire        SPEED_RESTRICT
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    wire [7:0] pin_raw;
    wire [7:0] pin;

    assign pin_raw = {HEAT_SHUTDOWN_HOLD, HEAT_SHUTDOWN_ABOVE, HEAT_WARNING_HOLD,
                      HEAT_WARNING_ABOVE, PUMP_RAIL_UV, STEP_DOWN_FEEDBACK_UV,
                      ANALOG_RAIL_UV, MOTOR_SUPPLY_UV};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
            mdfr_sync u_sync (
                .CLK    (CLK),
                .ARST_N (ARST_N),
                .PIN    (pin_raw[gi]),
                .LEVEL  (pin[gi])
            );
        end
    endgenerate

    wire motor_uv   = pin[0];
    wire analog_uv  = pin[1];
    wire step_uv    = pin[2];
    wire pump_uv    = pin[3];
    wire warn_above = pin[4];
    wire warn_hold  = pin[5];
    wire shut_above = pin[6];
    wire shut_hold  = pin[7];

    // Any rail lockout holds configuration, timers and fault flags at reset values
    wire lockout = motor_uv | analog_uv | step_uv; // RULE10 RULE11 RULE12

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    reg  [`MDFR_CFG_WIDTH-1:0] cfg;
    reg  [7:0]                 wdt_interval;
    reg                        dp_write;
    reg  [7:0]                 dp_addr;
    wire [31:0]                status;

    wire ap_valid = HSEL & HREADY & HTRANS[1];
    wire wr_cfg   = dp_write & (dp_addr == `MDFR_CFG_OFS);
    wire wr_wdt   = dp_write & (dp_addr == `MDFR_WDT_OFS);
    wire wr_ctrl  = dp_write & (dp_addr == `MDFR_CTRL_OFS);
    wire clear    = wr_ctrl & HWDATA[`MDFR_CTRL_CLEAR];
    wire tickle   = wr_ctrl & HWDATA[`MDFR_CTRL_TICKLE];

    // Zero wait states, so the bus never stalls
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
            HRDATA   <= 32'h0000_0000;
        end else begin
            dp_write <= ap_valid & HWRITE;
            dp_addr  <= {HADDR[7:2], 2'b00};
            if (ap_valid & ~HWRITE) begin
                case ({HADDR[7:2], 2'b00})
                    `MDFR_CFG_OFS:  HRDATA <= {17'h00000, cfg};
                    `MDFR_WDT_OFS:  HRDATA <= {24'h000000, wdt_interval};
                    `MDFR_STAT_OFS: HRDATA <= status;
                    default:        HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg          <= `MDFR_CFG_RESET;
            wdt_interval <= `MDFR_WDT_RESET;
        end else if (lockout) begin
            cfg          <= `MDFR_CFG_RESET;
            wdt_interval <= `MDFR_WDT_RESET;
        end else begin
            if (wr_cfg) begin
                cfg <= HWDATA[`MDFR_CFG_WIDTH-1:0];
            end
            if (wr_wdt) begin
                wdt_interval <= HWDATA[7:0];
            end
        end
    end

    wire       pto_en   = cfg[`MDFR_CFG_PTO_EN];
    wire       prate_en = cfg[`MDFR_CFG_PRATE_EN];
    wire [2:0] up_lim   = cfg[`MDFR_CFG_UPLIM_LSB+2:`MDFR_CFG_UPLIM_LSB];
    wire       up_mode  = cfg[`MDFR_CFG_UP_MODE];
    wire [2:0] lo_lim   = cfg[`MDFR_CFG_LOLIM_LSB+2:`MDFR_CFG_LOLIM_LSB];
    wire       lo_mode  = cfg[`MDFR_CFG_LO_MODE];
    wire       wdt_en   = cfg[`MDFR_CFG_WDT_EN];
    wire       wdt_act  = cfg[`MDFR_CFG_WDT_ACT];
    wire       cap_en   = cfg[`MDFR_CFG_CAP_EN];
    wire       sat_en   = cfg[`MDFR_CFG_SAT_EN];
    wire       hwr_en   = cfg[`MDFR_CFG_HWR_EN];

    // ---------------------------------------------------------------
    // Supply limits
    // ---------------------------------------------------------------
    wire [7:0] up_thr = `MDFR_UP_BASE + (`MDFR_UP_STEP * {5'h00, up_lim});
    wire [7:0] lo_thr = `MDFR_LO_BASE + (`MDFR_LO_STEP * {5'h00, lo_lim});

    wire up_over  = (up_lim != 3'b000) & (SUPPLY_LEVEL > up_thr); // RULE3
    wire up_back  = SUPPLY_LEVEL < (up_thr - `MDFR_UP_HYS); // RULE3
    wire lo_under = (lo_lim != 3'b000) & (SUPPLY_LEVEL < lo_thr); // RULE4
    wire lo_back  = SUPPLY_LEVEL > (lo_thr + `MDFR_LO_HYS); // RULE4

    // ---------------------------------------------------------------
    // Probe supervision and retry timer
    // ---------------------------------------------------------------
    reg  [31:0] probe_cnt;
    reg  [31:0] retry_cnt;
    reg         retry_run;
    reg         f_pto;
    reg         f_prate;

    wire pto_hit   = pto_en & PROBE_RAMP_ACTIVE & (probe_cnt == PROBE_TO_CYC); // RULE1
    wire prate_hit = prate_en & PROBE_PULSE_START & ~PROBE_DECAYED; // RULE2
    wire retry_end = retry_run & (retry_cnt == 32'h0000_0001);

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            probe_cnt <= 32'h0000_0000;
            retry_cnt <= 32'h0000_0000;
            retry_run <= 1'b0;
            f_pto     <= 1'b0;
            f_prate   <= 1'b0;
        end else if (lockout) begin
            probe_cnt <= 32'h0000_0000;
            retry_cnt <= 32'h0000_0000;
            retry_run <= 1'b0;
            f_pto     <= 1'b0;
            f_prate   <= 1'b0;
        end else begin
            // Counter saturates so a stuck ramp reports only once
            if (!PROBE_RAMP_ACTIVE) begin
                probe_cnt <= 32'h0000_0000;
            end else if (probe_cnt <= PROBE_TO_CYC) begin
                probe_cnt <= probe_cnt + 32'h0000_0001;
            end
            if (pto_hit | prate_hit) begin
                retry_cnt <= RETRY_CYC; // RULE17
                retry_run <= 1'b1;
            end else if (retry_run) begin
                retry_cnt <= retry_cnt - 32'h0000_0001;
                if (retry_end) begin
                    retry_run <= 1'b0; // RULE17
                end
            end
            if (pto_hit) begin
                f_pto <= 1'b1; // RULE1
            end else if (retry_end) begin
                f_pto <= 1'b0; // RULE17
            end
            if (prate_hit) begin
                f_prate <= 1'b1; // RULE2
            end else if (retry_end) begin
                f_prate <= 1'b0; // RULE17
            end
        end
    end

    // ---------------------------------------------------------------
    // Host tickle watchdog
    // ---------------------------------------------------------------
    reg [31:0] tick_cnt;
    reg [7:0]  ms_cnt;
    reg        f_wdt;

    wire ms_tick = (tick_cnt == WDT_TICK_CYC - 1);
    wire wdt_hit = wdt_en & ~tickle & ms_tick & (ms_cnt + 8'h01 >= wdt_interval); // RULE5

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_cnt <= 32'h0000_0000;
            ms_cnt   <= 8'h00;
            f_wdt    <= 1'b0;
        end else if (lockout) begin
            tick_cnt <= 32'h0000_0000;
            ms_cnt   <= 8'h00;
            f_wdt    <= 1'b0;
        end else begin
            if (!wdt_en | tickle | ms_tick) begin
                tick_cnt <= 32'h0000_0000;
            end else begin
                tick_cnt <= tick_cnt + 32'h0000_0001;
            end
            if (!wdt_en | tickle | wdt_hit) begin
                ms_cnt <= 8'h00;
            end else if (ms_tick) begin
                ms_cnt <= ms_cnt + 8'h01;
            end
            // Set wins over a clear in the same cycle
            if (wdt_hit) begin
                f_wdt <= 1'b1; // RULE5
            end else if (clear) begin
                f_wdt <= 1'b0; // RULE15
            end
        end
    end

    // ---------------------------------------------------------------
    // Level faults and their recovery
    // ---------------------------------------------------------------
    reg f_up;
    reg f_lo;
    reg f_cap;
    reg f_csat;
    reg f_ssat;
    reg f_warn;
    reg f_shut;
    reg f_pump;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            f_up   <= 1'b0;
            f_lo   <= 1'b0;
            f_cap  <= 1'b0;
            f_csat <= 1'b0;
            f_ssat <= 1'b0;
            f_warn <= 1'b0;
            f_shut <= 1'b0;
            f_pump <= 1'b0;
        end else if (lockout) begin
            f_up   <= 1'b0;
            f_lo   <= 1'b0;
            f_cap  <= 1'b0;
            f_csat <= 1'b0;
            f_ssat <= 1'b0;
            f_warn <= 1'b0;
            f_shut <= 1'b0;
            f_pump <= 1'b0;
        end else begin
            if (up_over) begin
                f_up <= 1'b1; // RULE3
            end else if (up_mode ? up_back : clear) begin
                f_up <= 1'b0; // RULE3 RULE15
            end
            if (lo_under) begin
                f_lo <= 1'b1; // RULE4
            end else if (lo_mode ? lo_back : clear) begin
                f_lo <= 1'b0; // RULE4 RULE15
            end
            f_cap <= cap_en & SUPPLY_CURRENT_OVER; // RULE6
            if (sat_en & CURRENT_LOOP_SAT) begin
                f_csat <= 1'b1; // RULE7
            end else if (!sat_en | REFERENCE_REACHED) begin
                f_csat <= 1'b0; // RULE7
            end
            if (sat_en & SPEED_LOOP_SAT) begin
                f_ssat <= 1'b1; // RULE7
            end else if (!sat_en | REFERENCE_REACHED) begin
                f_ssat <= 1'b0; // RULE7
            end
            if (hwr_en & warn_above) begin
                f_warn <= 1'b1; // RULE8
            end else if (!hwr_en | !warn_hold) begin
                f_warn <= 1'b0; // RULE8
            end
            if (shut_above) begin
                f_shut <= 1'b1; // RULE9
            end else if (!shut_hold) begin
                f_shut <= 1'b0; // RULE9
            end
            if (pump_uv) begin
                f_pump <= 1'b1; // RULE13
            end else if (clear) begin
                f_pump <= 1'b0; // RULE14
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs and status
    // ---------------------------------------------------------------
    wire driver_fault = f_warn | f_shut | pump_uv; // RULE8 RULE9 RULE13
    wire ctrl_fault   = f_pto | f_prate | f_up | f_lo | f_wdt | f_cap | f_csat | f_ssat;
    wire stage_hiz    = f_pto | f_prate | f_up | f_lo | (f_wdt & wdt_act) | f_shut
                        | pump_uv; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE9 RULE13

    assign FAULT_INDICATOR_PIN_N   = lockout | ~(driver_fault | ctrl_fault); // RULE16
    assign STAGE_ENABLE            = ~lockout & ~stage_hiz; // RULE10 RULE11
    assign PUMP_ENABLE             = ~(motor_uv | analog_uv); // RULE10 RULE11
    assign STEP_DOWN_SWITCH_ENABLE = ~step_uv; // RULE12
    assign CONTROLLER_ACTIVE       = ~lockout; // RULE10 RULE11 RULE12
    assign SPEED_RESTRICT          = f_cap; // RULE6

    assign status = {18'h00000, stage_hiz, f_pump, f_shut, f_warn, f_ssat, f_csat,
                     f_cap, f_wdt, f_lo, f_up, f_prate, f_pto, ctrl_fault, driver_fault};
endmodule // mdfr_fault_response

// file: mdfr_fault_response_properties.sv
// Concurrent checks on the fault response block ports
`timescale 1ns/10ps
module mdfr_fault_checker (
    input logic CLK,
    input logic ARST_N,
    input logic SUPPLY_CURRENT_OVER,
    input logic MOTOR_SUPPLY_UV,
    input logic ANALOG_RAIL_UV,
    input logic STEP_DOWN_FEEDBACK_UV,
    input logic PUMP_RAIL_UV,
    input logic HEAT_SHUTDOWN_ABOVE,
    input logic FAULT_INDICATOR_PIN_N,
    input logic STAGE_ENABLE,
    input logic PUMP_ENABLE,
    input logic STEP_DOWN_SWITCH_ENABLE,
    input logic CONTROLLER_ACTIVE,
    input logic SPEED_RESTRICT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    // Eight samples cover the pin synchroniser with margin
    property p_mot_lock;
        MOTOR_SUPPLY_UV[*8] |-> !CONTROLLER_ACTIVE && !PUMP_ENABLE && !STAGE_ENABLE;
    endproperty
    a_mot_lock: assert property (p_mot_lock) else $error("motor lockout");
    property p_ana_lock;
        ANALOG_RAIL_UV[*8] |-> !CONTROLLER_ACTIVE && !PUMP_ENABLE && !STAGE_ENABLE;
    endproperty
    a_ana_lock: assert property (p_ana_lock) else $error("analog lockout");
    property p_step_lock;
        STEP_DOWN_FEEDBACK_UV[*8] |-> !STEP_DOWN_SWITCH_ENABLE && !CONTROLLER_ACTIVE;
    endproperty
    a_step_lock: assert property (p_step_lock) else $error("step-down lockout");
    property p_pump_low;
        PUMP_RAIL_UV[*8] |-> !STAGE_ENABLE && (FAULT_INDICATOR_PIN_N == !CONTROLLER_ACTIVE);
    endproperty
    a_pump_low: assert property (p_pump_low) else $error("pump low response");
    property p_heat_off;
        HEAT_SHUTDOWN_ABOVE[*8] |-> !STAGE_ENABLE && (FAULT_INDICATOR_PIN_N == !CONTROLLER_ACTIVE);
    endproperty
    a_heat_off: assert property (p_heat_off) else $error("heat shutdown");
    property p_cap_set;
        $rose(SPEED_RESTRICT) |-> $past(SUPPLY_CURRENT_OVER);
    endproperty
    a_cap_set: assert property (p_cap_set) else $error("restrict without cause");
    property p_cap_clr;
        SPEED_RESTRICT && !SUPPLY_CURRENT_OVER |=> !SPEED_RESTRICT;
    endproperty
    a_cap_clr: assert property (p_cap_clr) else $error("restrict kept");
    property p_pin_hiz;
        CONTROLLER_ACTIVE && !STAGE_ENABLE |-> !FAULT_INDICATOR_PIN_N;
    endproperty
    a_pin_hiz: assert property (p_pin_hiz) else $error("hi-z not reported");
endmodule // mdfr_fault_checker
bind mdfr_fault_response mdfr_fault_checker u_chk (.CLK(CLK), .ARST_N(ARST_N),
    .SUPPLY_CURRENT_OVER(SUPPLY_CURRENT_OVER), .MOTOR_SUPPLY_UV(MOTOR_SUPPLY_UV),
    .ANALOG_RAIL_UV(ANALOG_RAIL_UV), .STEP_DOWN_FEEDBACK_UV(STEP_DOWN_FEEDBACK_UV),
    .PUMP_RAIL_UV(PUMP_RAIL_UV), .HEAT_SHUTDOWN_ABOVE(HEAT_SHUTDOWN_ABOVE),
    .FAULT_INDICATOR_PIN_N(FAULT_INDICATOR_PIN_N), .STAGE_ENABLE(STAGE_ENABLE),
    .PUMP_ENABLE(PUMP_ENABLE), .STEP_DOWN_SWITCH_ENABLE(STEP_DOWN_SWITCH_ENABLE),
    .CONTROLLER_ACTIVE(CONTROLLER_ACTIVE), .SPEED_RESTRICT(SPEED_RESTRICT));

// file: mdfr_host_model.sv
// Host controller model: AHB-Lite master with clear and tickle
`timescale 1ns/10ps
`include "mdfr_defs.vh"
module mdfr_host_model (
    input  logic        CLK,
    input  logic        HREADY,
    input  logic [31:0] HRDATA,
    output logic        HSEL,
    output logic [31:0] HADDR,
    output logic [1:0]  HTRANS,
    output logic        HWRITE,
    output logic [2:0]  HSIZE,
    output logic [31:0] HWDATA
);
    initial begin
        HSEL = 1'h0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'h0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge CLK);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        @(posedge CLK);
        while (HREADY !== 1'h1) @(posedge CLK);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADY !== 1'h1) @(posedge CLK);
        q = HRDATA;
        // Released data never echoes the last word
        HWDATA <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'h0, a, 32'h0, q);
    endtask
    task automatic clr;
        wr(`MDFR_CTRL_OFS, 32'h1);
    endtask
    task automatic tickle;
        wr(`MDFR_CTRL_OFS, 32'h2);
    endtask
endmodule // mdfr_host_model

// file: test_mdfr_fault_response.sv
// Self-checking testbench for the fault response block
`timescale 1ns/10ps
`include "mdfr_defs.vh"
module test_mdfr_fault_response;
    // ins: 0 cap, 1/2 loop sat, 3 ref, 4 ramp, 5 start, 6 decayed, 7-10 uv, 11-14 heat
    localparam logic [14:0] BASE = 15'h0048;
    logic        CLK = 1'h0;
    logic        ARST_N = 1'h0;
    logic [14:0] ins = BASE;
    logic [7:0]  lvl = 8'h20;
    wire         hsel, hwrite, hrdy, hresp;
    wire [31:0]  haddr, hwdata, hrdata;
    wire [1:0]   htrans;
    wire [2:0]   hsize;
    wire [5:0]   pins;
    int          bad_count = 0;
    int          comparisons = 0;
    always #2.5 CLK = ~CLK;
    mdfr_host_model host (.CLK(CLK), .HREADY(hrdy), .HRDATA(hrdata), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
    mdfr_fault_response #(.PROBE_TO_CYC(50), .RETRY_CYC(30), .WDT_TICK_CYC(10)) DUT (
        .CLK(CLK), .ARST_N(ARST_N), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy),
        .HRESP(hresp), .HRDATA(hrdata), .SUPPLY_LEVEL(lvl), .SUPPLY_CURRENT_OVER(ins[0]),
        .CURRENT_LOOP_SAT(ins[1]), .SPEED_LOOP_SAT(ins[2]), .REFERENCE_REACHED(ins[3]),
        .PROBE_RAMP_ACTIVE(ins[4]), .PROBE_PULSE_START(ins[5]), .PROBE_DECAYED(ins[6]),
        .MOTOR_SUPPLY_UV(ins[7]), .ANALOG_RAIL_UV(ins[8]), .STEP_DOWN_FEEDBACK_UV(ins[9]),
        .PUMP_RAIL_UV(ins[10]), .HEAT_WARNING_ABOVE(ins[11]), .HEAT_WARNING_HOLD(ins[12]),
        .HEAT_SHUTDOWN_ABOVE(ins[13]), .HEAT_SHUTDOWN_HOLD(ins[14]),
        .FAULT_INDICATOR_PIN_N(pins[5]), .STAGE_ENABLE(pins[4]), .PUMP_ENABLE(pins[3]),
        .STEP_DOWN_SWITCH_ENABLE(pins[2]), .CONTROLLER_ACTIVE(pins[1]),
        .SPEED_RESTRICT(pins[0]));
    // ------------------------------------------------------------
    // Helpers; pins = fault_n, stage, pump, step-down, ctrl, restrict
    // ------------------------------------------------------------
    task automatic drv(input logic [14:0] v, input logic [7:0] l);
        @(posedge CLK);
        ins <= v;
        lvl <= l;
        // Covers the synchroniser and one flag update
        repeat (8) @(posedge CLK);
    endtask
    task automatic chk_pins(input logic [5:0] e);
        comparisons++;
        if (pins !== e) begin
            bad_count++;
            $display("[ERR] %0t pins %b exp %b", $time, pins, e);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        host.rd(a, q);
        comparisons++;
        if ((q & m) !== e || hresp !== 1'h0) begin
            bad_count++;
            $display("[ERR] %0t reg %h got %h exp %h", $time, a, q, e);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_rails;
        logic [5:0] e [3] = '{6'h24, 6'h24, 6'h28};
        chk_pins(6'h3E);
        chk_reg(`MDFR_WDT_OFS, 32'hFF, 32'hFF);
        chk_reg(8'h40, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 3; i++) begin
            host.wr(`MDFR_CFG_OFS, 32'h7FFF);
            chk_reg(`MDFR_CFG_OFS, 32'hFFFFFFFF, 32'h7FFF);
            drv(BASE | (15'h80 << i), 8'h20);
            chk_pins(e[i]);
            drv(BASE, 8'h20);
            chk_reg(`MDFR_CFG_OFS, 32'hFFFFFFFF, 32'h0);
        end
    endtask
    task automatic t_pump;
        drv(BASE | 15'h400, 8'h20);
        chk_pins(6'h0E);
        chk_reg(`MDFR_STAT_OFS, 32'h1001, 32'h1001);
        drv(BASE, 8'h20);
        chk_pins(6'h3E);
        chk_reg(`MDFR_STAT_OFS, 32'h1000, 32'h1000);
        host.clr();
        chk_reg(`MDFR_STAT_OFS, 32'h1000, 32'h0);
    endtask
    task automatic t_supply;
        logic [7:0] l [6] = '{8'h2D, 8'h2A, 8'h29, 8'h09, 8'h0B, 8'h0C};
        host.wr(`MDFR_CFG_OFS, 32'h4);
        drv(BASE, 8'h2D);
        chk_reg(`MDFR_STAT_OFS, 32'h10, 32'h10);
        host.clr();
        drv(BASE, 8'h20);
        chk_pins(6'h0E);
        host.clr();
        drv(BASE, 8'h20);
        chk_pins(6'h3E);
        for (int i = 0; i < 6; i++) begin
            if (i % 3 == 0) host.wr(`MDFR_CFG_OFS, (i == 0) ? 32'h24 : 32'h240);
            drv(BASE, l[i]);
            chk_pins((i % 3 == 2) ? 6'h3E : 6'h0E);
        end
        host.wr(`MDFR_CFG_OFS, 32'h40);
        drv(BASE, 8'h09);
        drv(BASE, 8'h20);
        chk_pins(6'h0E);
        host.clr();
        drv(BASE, 8'h20);
        chk_pins(6'h3E);
    endtask
    task automatic t_probe;
        drv(BASE | 15'h10, 8'h20);
        repeat (50) @(posedge CLK);
        chk_pins(6'h3E);
        drv(BASE, 8'h20);
        host.wr(`MDFR_CFG_OFS, 32'h1);
        drv(BASE | 15'h10, 8'h20);
        repeat (50) @(posedge CLK);
        chk_pins(6'h0E);
        chk_reg(`MDFR_STAT_OFS, 32'h6, 32'h6);
        drv(BASE, 8'h20);
        chk_pins(6'h0E);
        repeat (20) @(posedge CLK);
        chk_pins(6'h3E);
        chk_reg(`MDFR_STAT_OFS, 32'h2, 32'h0);
        host.wr(`MDFR_CFG_OFS, 32'h2);
        drv(15'h0008, 8'h20);
        ins[5] <= 1'h1;
        @(posedge CLK);
        ins[5] <= 1'h0;
        repeat (4) @(posedge CLK);
        chk_pins(6'h0E);
        drv(BASE, 8'h20);
        repeat (30) @(posedge CLK);
        chk_pins(6'h3E);
    endtask
    task automatic t_heat;
        logic [14:0] v [6] = '{15'h1848, 15'h1048, BASE, 15'h6048, 15'h4048, BASE};
        logic [5:0]  e [6] = '{6'h1E, 6'h1E, 6'h3E, 6'h0E, 6'h0E, 6'h3E};
        host.wr(`MDFR_CFG_OFS, 32'h4000);
        for (int i = 0; i < 6; i++) begin
            drv(v[i], 8'h20);
            chk_pins(e[i]);
        end
        host.wr(`MDFR_CFG_OFS, 32'h0);
        drv(15'h1848, 8'h20);
        chk_pins(6'h3E);
    endtask
    task automatic t_misc;
        host.wr(`MDFR_CFG_OFS, 32'h3000);
        drv(BASE | 15'h1, 8'h20);
        chk_pins(6'h1F);
        for (int i = 1; i < 3; i++) begin
            drv(15'h0040 | (15'h1 << i), 8'h20);
            chk_pins(6'h1E);
            drv(15'h0040, 8'h20);
            chk_pins(6'h1E);
            drv(BASE, 8'h20);
            chk_pins(6'h3E);
        end
    endtask
    task automatic t_wdt;
        host.wr(`MDFR_WDT_OFS, 32'h2);
        host.wr(`MDFR_CFG_OFS, 32'hC00);
        repeat (6) host.tickle();
        chk_pins(6'h3E);
        repeat (40) @(posedge CLK);
        chk_pins(6'h0E);
        for (int i = 0; i < 2; i++) begin
            host.wr(`MDFR_CFG_OFS, 32'h0);
            host.clr();
            drv(BASE, 8'h20);
            chk_pins(6'h3E);
            if (i == 0) host.wr(`MDFR_CFG_OFS, 32'h400);
            if (i == 0) repeat (40) @(posedge CLK);
            if (i == 0) chk_pins(6'h1E);
        end
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        ARST_N <= 1'h1;
        t_rails();
        t_pump();
        t_supply();
        t_probe();
        t_heat();
        t_misc();
        t_wdt();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        $display("[ERR] %0t timeout", $time);
        test_done();
    end
endmodule // test_mdfr_fault_response
